// ===== cod_map.vh
// constants for the code option decoder: offsets, fields, codes, timing
// assumes pclk at 20 MHz and a 12-bit apb byte address
`ifndef COD_MAP_VH
`define COD_MAP_VH

// =====================================================================
// register byte offsets
`define COD_ADDR_WORD0 12'h000
`define COD_ADDR_WORD1 12'h004
`define COD_ADDR_CTRL 12'h008
`define COD_ADDR_STATUS 12'h00c

// =====================================================================
// option word layout
`define COD_WORD_W 13
`define COD_W0_RSVD_MASK 13'h1c00
`define COD_W0_TYPE_MASK 13'h0200
`define COD_W1_RSVD_MASK 13'h1800
`define COD_W0_INSTR_PERIOD_SEL 8
`define COD_W0_WDT_N 7
`define COD_W0_OSC_HI 6
`define COD_W0_OSC_LO 4
`define COD_W0_PWR 3
`define COD_W0_PROT_HI 2
`define COD_W1_CLKOUT 10
`define COD_W1_PULSE 9
`define COD_W1_NRE 8
`define COD_W1_WATCHDOG_PERIOD_SEL 7
`define COD_W1_BRANCH 6
`define COD_W1_TRIM_HI 5
`define COD_W1_TRIM_LO 2
`define COD_W1_RCF_HI 1
`define COD_WORD_DEFAULT 13'h1fff

// =====================================================================
// oscillator field codes
`define COD_OSC_ERC_GPIO 3'h0
`define COD_OSC_ERC_CLK 3'h1
`define COD_OSC_IRC_GPIO 3'h2
`define COD_OSC_IRC_CLK 3'h3
`define COD_OSC_LXT 3'h6
`define COD_OSC_HXT 3'h7

// =====================================================================
// internal rc frequency in khz per code
`define COD_RCF_W 14
`define COD_RCF_4M 14'h0fa0
`define COD_RCF_8M 14'h1f40
`define COD_RCF_1M 14'h03e8
`define COD_RCF_455K 14'h01c7

// =====================================================================
// timing
`define COD_CLK_MHZ 20
`define COD_WDT_LONG_US 18000
`define COD_WDT_SHORT_US 4500
`define COD_WDT_CNT_W 20
`define COD_PULSE_SHORT 6'h08
`define COD_PULSE_LONG 6'h20
`define COD_SETTLE_CYCLES 2'h3

`endif

// ===== cod_sync.v
// three-stage synchroniser for static or slow pins
// assumes the pin is asynchronous to pclk; dout moves when stage 2 and 3 agree
`timescale 1ns/1ps
`include "cod_map.vh"
module cod_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // pin side
    input wire [WIDTH-1:0] din,
    // core side
    output reg [WIDTH-1:0] dout,
    output reg valid
);
    reg [WIDTH-1:0] s1_r;
    reg [WIDTH-1:0] s2_r;
    reg [WIDTH-1:0] s3_r;
    reg [1:0] fill_r;

    // =================================================================
    // stages
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            fill_r <= 2'h0;
            dout <= INIT;
            valid <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (fill_r != `COD_SETTLE_CYCLES) begin
                fill_r <= fill_r + 2'h1;
            end
            // agreement only counts once all stages hold real pin samples
            if (s2_r == s3_r && fill_r == `COD_SETTLE_CYCLES) begin
                dout <= s3_r;
                valid <= 1'b1;
            end
        end
    end
endmodule // cod_sync

// ===== cod_noise_filter.v
// int pin noise rejection: a level change is taken after it stands long enough
// assumes din is already synchronous to clk
`timescale 1ns/1ps
`include "cod_map.vh"
module cod_noise_filter (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // control
    input wire enable,
    input wire long_sel,
    // data
    input wire din,
    output reg dout
);
    reg [5:0] cnt_r;
    wire [5:0] thr;

    assign thr = long_sel ? `COD_PULSE_LONG : `COD_PULSE_SHORT;

    // =================================================================
    // filter
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 6'h00;
            dout <= 1'b0;
        end else if (!enable) begin
            cnt_r <= 6'h00;
            dout <= din;
        end else if (din == dout) begin
            cnt_r <= 6'h00;
        end else if (cnt_r == thr - 6'h01) begin
            cnt_r <= 6'h00;
            dout <= din;
        end else begin
            cnt_r <= cnt_r + 6'h01;
        end
    end
endmodule // cod_noise_filter

// ===== cod_option_decoder.v
// code option decoder: samples the two option words after reset, decodes them
// assumes option word pins are static otp outputs, sampled through synchronisers
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "cod_map.vh"

// How it works
// - two 13-bit option words, id word separate
// - word zero top three bits read one
// - part type bit always reads one
// - period bit: zero two, one four clocks
// - watchdog enable bit is active low
// - oscillator field picks mode and pin use
// - crystal modes keep both oscillator pins
// - internal rc frees oscillator input pin
// - power class bit: low or high power
// - protection on unless all three ones
// - word one top two bits read one
// - rc clock codes: clock out or open drain
// - pulse width bit selects 8 or 32
// - noise rejection enable, off in lxt
// - noise rejection off during sleep
// - watchdog period 18 ms or 4.5 ms
// - branch bit selects one or two cycles
// - rc frequency bits pick 4,8,1 MHz, 455kHz
// - pc-changing instructions take selected cycle count
module cod_option_decoder #(
    parameter integer WDT_LONG_CYCLES = `COD_WDT_LONG_US * `COD_CLK_MHZ,
    parameter integer WDT_SHORT_CYCLES = `COD_WDT_SHORT_US * `COD_CLK_MHZ
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // otp option words
    input wire [12:0] option_word_zero_pin,
    input wire [12:0] option_word_one_pin,
    // core sleep state and int pin
    input wire core_sleep,
    input wire int_pin,
    // decoded configuration
    output reg config_loaded,
    output reg instr_period_sel,
    output reg [2:0] instr_osc_periods,
    output reg watchdog_enable,
    output reg watchdog_period_sel,
    output reg [19:0] watchdog_timeout_cycles,
    output reg external_rc_mode,
    output reg internal_rc_mode,
    output reg low_freq_crystal_mode,
    output reg high_freq_crystal_mode,
    output reg oscillator_in_pin_gpio,
    output reg oscillator_out_pin_gpio,
    output reg oscillator_out_drive_clock,
    output reg oscillator_out_open_drain,
    output reg power_class_sel,
    output reg code_protect,
    output reg glitch_filter_active,
    output reg pulse_width_sel,
    output reg branch_cycle_sel,
    output reg [1:0] pc_change_cycles,
    output reg rc_trim_auto,
    output reg [13:0] rc_freq_khz,
    output reg int_filtered
);
    // =================================================================
    // declarations
    reg [12:0] word0_r;
    reg [12:0] word1_r;
    reg loaded_r;
    reg sleep_req_r;

    wire [12:0] word0_sync;
    wire [12:0] word1_sync;
    wire word0_ok;
    wire word1_ok;
    wire int_sync;
    wire int_clean;

    wire [12:0] word0_view;
    wire [12:0] word1_view;
    wire [2:0] osc;
    wire [1:0] rcf;
    wire sleeping;
    wire filt_en;

    wire apb_access;
    wire hit_word0;
    wire hit_word1;
    wire hit_ctrl;
    wire hit_status;
    wire hit;

    reg [31:0] rd_nxt;
    reg erc_nxt;
    reg irc_nxt;
    reg lxt_nxt;
    reg hxt_nxt;
    reg [13:0] rcf_nxt;

    // =================================================================
    // pin synchronisers
    cod_sync #(
        .WIDTH(13),
        .INIT(`COD_WORD_DEFAULT)
    ) u_sync_word0 (
        .clk(pclk),
        .rst_n(presetn),
        .din(option_word_zero_pin),
        .dout(word0_sync),
        .valid(word0_ok)
    );

    cod_sync #(
        .WIDTH(13),
        .INIT(`COD_WORD_DEFAULT)
    ) u_sync_word1 (
        .clk(pclk),
        .rst_n(presetn),
        .din(option_word_one_pin),
        .dout(word1_sync),
        .valid(word1_ok)
    );

    cod_sync #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_sync_int (
        .clk(pclk),
        .rst_n(presetn),
        .din(int_pin),
        .dout(int_sync),
        .valid()
    );

    // =================================================================
    // one-shot capture after reset release
    // otp words never change in service, so a later edit is not followed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word0_r <= `COD_WORD_DEFAULT;
            word1_r <= `COD_WORD_DEFAULT;
            loaded_r <= 1'b0;
        end else if (!loaded_r && word0_ok && word1_ok) begin
            word0_r <= word0_sync;
            word1_r <= word1_sync;
            loaded_r <= 1'b1;
        end
    end

    // reserved and type bits forced so the programmed value never shows
    assign word0_view = word0_r | `COD_W0_RSVD_MASK | `COD_W0_TYPE_MASK;
    assign word1_view = word1_r | `COD_W1_RSVD_MASK;

    assign osc = word0_r[`COD_W0_OSC_HI:`COD_W0_OSC_LO];
    assign rcf = word1_r[`COD_W1_RCF_HI:0];

    // =================================================================
    // oscillator mode decode
    always @* begin
        erc_nxt = 1'b0;
        irc_nxt = 1'b0;
        lxt_nxt = 1'b0;
        hxt_nxt = 1'b0;

        case (osc)
            `COD_OSC_ERC_GPIO: begin
                erc_nxt = 1'b1;
            end
            `COD_OSC_ERC_CLK: begin
                erc_nxt = 1'b1;
            end
            `COD_OSC_IRC_GPIO: begin
                irc_nxt = 1'b1;
            end
            `COD_OSC_IRC_CLK: begin
                irc_nxt = 1'b1;
            end
            `COD_OSC_LXT: begin
                lxt_nxt = 1'b1;
            end
            default: begin
                hxt_nxt = 1'b1;
            end
        endcase
    end

    // =================================================================
    // internal rc frequency decode
    always @* begin
        case (rcf)
            2'h3: begin
                rcf_nxt = `COD_RCF_4M;
            end
            2'h2: begin
                rcf_nxt = `COD_RCF_8M;
            end
            2'h1: begin
                rcf_nxt = `COD_RCF_1M;
            end
            default: begin
                rcf_nxt = `COD_RCF_455K;
            end
        endcase
    end

    // =================================================================
    // int pin noise rejection
    // lxt and sleep override the programmed enable
    assign sleeping = core_sleep | sleep_req_r;
    assign filt_en = word1_r[`COD_W1_NRE] & ~lxt_nxt & ~sleeping;

    cod_noise_filter u_filter (
        .clk(pclk),
        .rst_n(presetn),
        .enable(filt_en),
        .long_sel(word1_r[`COD_W1_PULSE]),
        .din(int_sync),
        .dout(int_clean)
    );

    // =================================================================
    // registered configuration outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_loaded <= 1'b0;
            instr_period_sel <= 1'b1;
            instr_osc_periods <= 3'h4;
            watchdog_enable <= 1'b0;
            watchdog_period_sel <= 1'b1;
            watchdog_timeout_cycles <= WDT_LONG_CYCLES[19:0];
            external_rc_mode <= 1'b0;
            internal_rc_mode <= 1'b0;
            low_freq_crystal_mode <= 1'b0;
            high_freq_crystal_mode <= 1'b1;
            oscillator_in_pin_gpio <= 1'b0;
            oscillator_out_pin_gpio <= 1'b0;
            oscillator_out_drive_clock <= 1'b0;
            oscillator_out_open_drain <= 1'b0;
            power_class_sel <= 1'b1;
            code_protect <= 1'b0;
            glitch_filter_active <= 1'b0;
            pulse_width_sel <= 1'b1;
            branch_cycle_sel <= 1'b1;
            pc_change_cycles <= 2'h2;
            rc_trim_auto <= 1'b1;
            rc_freq_khz <= `COD_RCF_4M;
            int_filtered <= 1'b0;
        end else begin
            config_loaded <= loaded_r;

            instr_period_sel <= word0_r[`COD_W0_INSTR_PERIOD_SEL];
            instr_osc_periods <= word0_r[`COD_W0_INSTR_PERIOD_SEL] ? 3'h4 : 3'h2;
            watchdog_enable <= ~word0_r[`COD_W0_WDT_N];
            watchdog_period_sel <= word1_r[`COD_W1_WATCHDOG_PERIOD_SEL];
            watchdog_timeout_cycles <= word1_r[`COD_W1_WATCHDOG_PERIOD_SEL] ?
                WDT_LONG_CYCLES[19:0] : WDT_SHORT_CYCLES[19:0];

            external_rc_mode <= erc_nxt;
            internal_rc_mode <= irc_nxt;
            low_freq_crystal_mode <= lxt_nxt;
            high_freq_crystal_mode <= hxt_nxt;
            // crystal modes own both pins; internal rc frees the input pin
            oscillator_in_pin_gpio <= irc_nxt;
            oscillator_out_pin_gpio <= (erc_nxt | irc_nxt) & ~osc[0];
            oscillator_out_drive_clock <= (erc_nxt | irc_nxt) & osc[0]
                & word1_r[`COD_W1_CLKOUT];
            oscillator_out_open_drain <= (erc_nxt | irc_nxt) & osc[0]
                & ~word1_r[`COD_W1_CLKOUT];
            power_class_sel <= word0_r[`COD_W0_PWR];
            code_protect <= ~&word0_r[`COD_W0_PROT_HI:0];
            glitch_filter_active <= filt_en;
            pulse_width_sel <= word1_r[`COD_W1_PULSE];
            branch_cycle_sel <= word1_r[`COD_W1_BRANCH];
            pc_change_cycles <= word1_r[`COD_W1_BRANCH] ? 2'h2 : 2'h1;
            // trim bits other than all ones break auto calibration
            rc_trim_auto <= &word1_r[`COD_W1_TRIM_HI:`COD_W1_TRIM_LO];
            rc_freq_khz <= rcf_nxt;
            int_filtered <= int_clean;
        end
    end

    // =================================================================
    // apb decode
    assign apb_access = psel & penable;

    assign hit_word0 = paddr == `COD_ADDR_WORD0;
    assign hit_word1 = paddr == `COD_ADDR_WORD1;
    assign hit_ctrl = paddr == `COD_ADDR_CTRL;
    assign hit_status = paddr == `COD_ADDR_STATUS;
    assign hit = hit_word0 | hit_word1 | hit_ctrl | hit_status;

    always @* begin
        rd_nxt = 32'h0000_0000;
        if (hit_word0) begin
            rd_nxt = {19'h00000, word0_view};
        end else if (hit_word1) begin
            rd_nxt = {19'h00000, word1_view};
        end else if (hit_ctrl) begin
            rd_nxt = {31'h0000_0000, sleep_req_r};
        end else if (hit_status) begin
            rd_nxt = {22'h000000, watchdog_enable, rc_trim_auto, int_filtered,
                glitch_filter_active, code_protect, high_freq_crystal_mode,
                low_freq_crystal_mode, internal_rc_mode, external_rc_mode,
                config_loaded};
        end
    end

    // =================================================================
    // apb slave: one wait state, write lands on the completing edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            sleep_req_r <= 1'b0;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            if (apb_access && !pready) begin
                pready <= 1'b1;
                pslverr <= ~hit;
                prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            end

            // the write lands on the edge that samples pready high
            if (apb_access && pready && pwrite && hit_ctrl) begin
                sleep_req_r <= pwdata[0];
            end
        end
    end
endmodule // cod_option_decoder

// ===== cod_option_decoder_properties.sv
// checker for the decoded configuration outputs and the word views
// assumes it is bound to cod_option_decoder, with one clock domain
`timescale 1ns/1ps
`include "cod_map.vh"
module cod_option_decoder_chk #(
    parameter integer WDT_LONG_CYCLES = 360000,
    parameter integer WDT_SHORT_CYCLES = 90000
) (
    // clock, reset and bus
    input wire pclk,
    input wire presetn,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire core_sleep,
    // decoded configuration
    input wire config_loaded,
    input wire instr_period_sel,
    input wire [2:0] instr_osc_periods,
    input wire watchdog_enable,
    input wire watchdog_period_sel,
    input wire [19:0] watchdog_timeout_cycles,
    input wire external_rc_mode,
    input wire internal_rc_mode,
    input wire low_freq_crystal_mode,
    input wire high_freq_crystal_mode,
    input wire oscillator_in_pin_gpio,
    input wire oscillator_out_pin_gpio,
    input wire oscillator_out_drive_clock,
    input wire oscillator_out_open_drain,
    input wire power_class_sel,
    input wire code_protect,
    input wire glitch_filter_active,
    input wire branch_cycle_sel,
    input wire [1:0] pc_change_cycles
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rc = external_rc_mode | internal_rc_mode;
    wire rd_done = pready & !pwrite & !pslverr;
    // ==========
    // properties
    property p_mode_onehot;
        config_loaded |-> $onehot({external_rc_mode, internal_rc_mode, low_freq_crystal_mode,
            high_freq_crystal_mode}) && !(external_rc_mode && internal_rc_mode);
    endproperty
    a_mode_onehot: assert property (p_mode_onehot)
        else $error("oscillator mode flags not one-hot");
    property p_period;
        instr_osc_periods == (instr_period_sel ? 3'h4 : 3'h2);
    endproperty
    a_period: assert property (p_period)
        else $error("instruction period count wrong");
    property p_wdt_time;
        watchdog_timeout_cycles == (watchdog_period_sel ? 20'(WDT_LONG_CYCLES)
            : 20'(WDT_SHORT_CYCLES));
    endproperty
    a_wdt_time: assert property (p_wdt_time)
        else $error("watchdog time-out count wrong");
    property p_pc_cycles;
        pc_change_cycles == (branch_cycle_sel ? 2'h2 : 2'h1);
    endproperty
    a_pc_cycles: assert property (p_pc_cycles)
        else $error("branch cycle count wrong");
    property p_in_pin;
        oscillator_in_pin_gpio == internal_rc_mode;
    endproperty
    a_in_pin: assert property (p_in_pin)
        else $error("oscillator input pin release wrong");
    property p_xtal_pins;
        (low_freq_crystal_mode || high_freq_crystal_mode) |-> !(oscillator_in_pin_gpio
            || oscillator_out_pin_gpio || oscillator_out_drive_clock || oscillator_out_open_drain);
    endproperty
    a_xtal_pins: assert property (p_xtal_pins)
        else $error("crystal mode pin given away");
    property p_clk_out;
        oscillator_out_drive_clock |-> rc && !oscillator_out_open_drain;
    endproperty
    a_clk_out: assert property (p_clk_out)
        else $error("clock output outside rc mode");
    property p_filter_off;
        (core_sleep || low_freq_crystal_mode) |=> !glitch_filter_active;
    endproperty
    a_filter_off: assert property (p_filter_off)
        else $error("noise filter active in sleep or lxt");
    property p_hold;
        config_loaded [*3] |-> $stable({power_class_sel, code_protect, watchdog_enable,
            high_freq_crystal_mode, pc_change_cycles, instr_period_sel});
    endproperty
    a_hold: assert property (p_hold)
        else $error("configuration moved after capture");
    property p_views;
        rd_done |-> (paddr != `COD_ADDR_WORD0 || prdata[12:9] == 4'hf)
            && (paddr != `COD_ADDR_WORD1 || prdata[12:11] == 2'h3);
    endproperty
    a_views: assert property (p_views)
        else $error("reserved option bits not read as one");
    property p_protect;
        rd_done && paddr == `COD_ADDR_WORD0 && config_loaded && $past(config_loaded) |->
            code_protect == (prdata[2:0] != 3'h7) && watchdog_enable == !prdata[7];
    endproperty
    a_protect: assert property (p_protect)
        else $error("protect or watchdog enable disagrees with word");
    c_lxt: cover property (low_freq_crystal_mode);
    c_err: cover property (pready && pslverr);
    c_filter: cover property (glitch_filter_active);
endmodule // cod_option_decoder_chk

bind cod_option_decoder cod_option_decoder_chk #(.WDT_LONG_CYCLES(WDT_LONG_CYCLES),
    .WDT_SHORT_CYCLES(WDT_SHORT_CYCLES)) u_chk (.pclk, .presetn, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .core_sleep, .config_loaded, .instr_period_sel,
    .instr_osc_periods, .watchdog_enable, .watchdog_period_sel, .watchdog_timeout_cycles,
    .external_rc_mode, .internal_rc_mode, .low_freq_crystal_mode, .high_freq_crystal_mode,
    .oscillator_in_pin_gpio, .oscillator_out_pin_gpio, .oscillator_out_drive_clock,
    .oscillator_out_open_drain, .power_class_sel, .code_protect, .glitch_filter_active,
    .branch_cycle_sel, .pc_change_cycles);

// ===== cod_prog_model.sv
// programmer model: presents the two option words on the otp pins
// assumes the bench sets the requested words while reset is held
`timescale 1ns/1ps
module cod_prog_model (
    // requested contents
    input wire [12:0] word0_req,
    input wire [12:0] word1_req,
    input wire trim_skip,
    // otp pins
    output wire [12:0] option_word_zero_pin,
    output wire [12:0] option_word_one_pin
);
    // ==========
    // programming
    assign option_word_zero_pin = word0_req;
    // trim burnt as ones; skipping it is an injected fault only
    assign option_word_one_pin = trim_skip ? word1_req : (word1_req | 13'h003c);
endmodule // cod_prog_model

// ===== test_code_option_decoder.sv
// self-checking bench: random option words, decoded outputs and apb views
// assumes cod_option_decoder, its checker and cod_prog_model are compiled
`timescale 1ns/1ps
`include "cod_map.vh"
module test_code_option_decoder;
    // ==========
    // signals
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, seed = 32'd57058;
    logic core_sleep = 1'b0, int_pin = 1'b0, trim_skip = 1'b0;
    logic [12:0] word0_req = 13'h1fff, word1_req = 13'h1fff;
    wire [12:0] option_word_zero_pin, option_word_one_pin;
    wire [31:0] prdata;
    wire [19:0] watchdog_timeout_cycles;
    wire [13:0] rc_freq_khz;
    wire [2:0] instr_osc_periods;
    wire [1:0] pc_change_cycles;
    wire pready, pslverr, config_loaded, instr_period_sel, watchdog_enable;
    wire watchdog_period_sel, external_rc_mode, internal_rc_mode, low_freq_crystal_mode;
    wire high_freq_crystal_mode, oscillator_in_pin_gpio, oscillator_out_pin_gpio;
    wire oscillator_out_drive_clock, oscillator_out_open_drain, power_class_sel;
    wire code_protect, glitch_filter_active, pulse_width_sel, branch_cycle_sel;
    wire rc_trim_auto, int_filtered;
    int num_errors = 0, n_checks = 0;
    int khz[4] = '{455, 1000, 8000, 4000};
    localparam int WDT_L = 1000, WDT_S = 250;
    always #25 pclk = ~pclk;

    cod_option_decoder #(.WDT_LONG_CYCLES(WDT_L), .WDT_SHORT_CYCLES(WDT_S))
        u_cod_option_decoder (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .option_word_zero_pin, .option_word_one_pin,
        .core_sleep, .int_pin, .config_loaded, .instr_period_sel, .instr_osc_periods,
        .watchdog_enable, .watchdog_period_sel, .watchdog_timeout_cycles,
        .external_rc_mode, .internal_rc_mode, .low_freq_crystal_mode,
        .high_freq_crystal_mode, .oscillator_in_pin_gpio, .oscillator_out_pin_gpio,
        .oscillator_out_drive_clock, .oscillator_out_open_drain, .power_class_sel,
        .code_protect, .glitch_filter_active, .pulse_width_sel, .branch_cycle_sel,
        .pc_change_cycles, .rc_trim_auto, .rc_freq_khz, .int_filtered);
    cod_prog_model u_cod_prog_model (.word0_req, .word1_req, .trim_skip,
        .option_word_zero_pin, .option_word_one_pin);

    // ==========
    // helpers
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task complete_run;
        if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        chk("pready", pready, 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // reference model of the decode, then the register views
    task check_cfg(input logic [12:0] w0, input logic [12:0] w1, input logic slp);
        logic [31:0] rd;
        logic err, e, i, l, rc, f;
        e = (w0[6:5] == 2'h0);
        i = (w0[6:5] == 2'h1);
        l = (w0[6:4] == 3'h6);
        rc = e | i;
        f = w1[8] & !l & !slp;
        chk("loaded", config_loaded, 1);
        chk("modes", {external_rc_mode, internal_rc_mode, low_freq_crystal_mode,
            high_freq_crystal_mode}, {e, i, l, !(rc | l)});
        chk("pins", {oscillator_in_pin_gpio, oscillator_out_pin_gpio,
            oscillator_out_drive_clock, oscillator_out_open_drain},
            {i, rc & !w0[4], rc & w0[4] & w1[10], rc & w0[4] & !w1[10]});
        chk("period", {instr_period_sel, instr_osc_periods}, {w0[8], w0[8] ? 3'h4 : 3'h2});
        chk("wdt", {watchdog_enable, watchdog_period_sel, watchdog_timeout_cycles},
            {!w0[7], w1[7], w1[7] ? 20'(WDT_L) : 20'(WDT_S)});
        chk("power", {power_class_sel, code_protect}, {w0[3], w0[2:0] != 3'h7});
        chk("filter", {glitch_filter_active, pulse_width_sel}, {f, w1[9]});
        chk("branch", {branch_cycle_sel, pc_change_cycles}, {w1[6], w1[6] ? 2'h2 : 2'h1});
        chk("rc", {rc_trim_auto, rc_freq_khz}, {&w1[5:2], 14'(khz[w1[1:0]])});
        apb(1'b1, `COD_ADDR_WORD0, 32'h0, rd, err);
        apb(1'b0, `COD_ADDR_WORD0, 32'h0, rd, err);
        chk("word0", rd, {19'h0, w0 | 13'h1e00});
        apb(1'b0, `COD_ADDR_WORD1, 32'h0, rd, err);
        chk("word1", rd, {19'h0, w1 | 13'h1800});
        apb(1'b0, `COD_ADDR_STATUS, 32'h0, rd, err);
        chk("status", rd, {22'h0, !w0[7], &w1[5:2], 1'b0, f, w0[2:0] != 3'h7,
            !(rc | l), l, i, e, 1'b1});
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk("unmapped", {rd[30:0], err}, 32'h1);
    endtask

    // ==========
    // main sequence: every oscillator and rc code, random other bits
    initial begin
        logic [31:0] r, rd;
        logic [12:0] w0, w1;
        logic err, slp, f;
        int k;
        for (int n = 0; n < 16; n++) begin
            r = xs();
            w0 = 13'(xs());
            w0[6:4] = n[2:0];
            if (n[0]) w0[2:0] = 3'h7;
            w1 = 13'(xs());
            w1[1:0] = n[3:2];
            presetn <= 1'b0;
            core_sleep <= r[0];
            trim_skip <= (n == 5);
            word0_req <= w0;
            word1_req <= w1;
            if (n != 5) w1 = w1 | 13'h003c;
            slp = r[0] | r[1];
            f = w1[8] & (w0[6:4] != 3'h6) & !slp;
            repeat (5) @(posedge pclk);
            presetn <= 1'b1;
            k = 0;
            while (config_loaded !== 1'b1 && k < 30) begin
                @(posedge pclk);
                k++;
            end
            repeat (2) @(posedge pclk);
            apb(1'b1, `COD_ADDR_CTRL, {31'h0, r[1]}, rd, err);
            apb(1'b0, `COD_ADDR_CTRL, 32'h0, rd, err);
            chk("ctrl", rd, {31'h0, r[1]});
            @(posedge pclk);
            check_cfg(w0, w1, slp);
            // a 22-cycle pulse passes the 8 filter but not the 32 one
            int_pin <= 1'b1;
            repeat (22) @(posedge pclk);
            chk("int_hi", int_filtered, !f | !w1[9]);
            int_pin <= 1'b0;
            repeat (60) @(posedge pclk);
            chk("int_lo", int_filtered, 0);
            word0_req <= ~w0;
            word1_req <= ~w1;
            repeat (10) @(posedge pclk);
            check_cfg(w0, w1, slp);
        end
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        complete_run();
    end
endmodule // test_code_option_decoder
